// ### hw/sample_skip_decimator.sv
// Post-trigger sample skip decimator top
//
// Notes on behaviour
// R1 - Enabled: emit sample where mask bit one
// R2 - Enabled: drop edges whose mask bit zero
// R3 - Host mask ones equal post-trigger samples
// R4 - One mask bit consumed per record edge
// R5 - Record length up to 65536 clocks
// R6 - Mode zero off, mode one on
// R7 - Disabled: keep every edge, ignore mask
// R8 - Mask held as 16-bit words
// R9 - Walk counts from first edge after trigger
// R10 - Host limits rate on one variant
// R11 - Mask bits least significant first
// R12 - Enabled: each trigger restarts the walk unless record length is zero
`timescale 1ns/1ns
`include "ssd_cfg.svh"
module sample_skip_decimator #(
  parameter int SAMPLE_BITS = `SSD_SAMPLE_BITS,
  parameter int WORDS       = `SSD_MASK_WORDS
) (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic                        clockEnable,
  input  wire logic                        skipMode,
  input  wire logic [`SSD_CNT_BITS-1:0]    recordClockCount,
  input  wire logic                        maskWriteValid,
  input  wire logic [`SSD_WADDR_BITS-1:0]  maskWriteIndex,
  input  wire logic [`SSD_WORD_BITS-1:0]   maskWriteWord,
  input  wire logic                        trigger,
  input  wire logic                        sampleValid,
  input  wire logic [SAMPLE_BITS-1:0]      sampleData,
  output logic                             outValid,
  output logic [SAMPLE_BITS-1:0]           outData,
  output logic                             recordActive
);

  // ****************************************
  // Local sizes
  // ****************************************

  // Counter must reach the full record ceiling
  localparam int CNT_BITS  = `SSD_CNT_BITS;
  localparam int WORD_BITS = `SSD_WORD_BITS;
  localparam int IDX_BITS  = `SSD_WADDR_BITS;

  // ****************************************
  // State
  // ****************************************

  typedef struct packed {
    ssd_pkg::ssd_state_e           fsm;
    logic [CNT_BITS-1:0]           edgeCount;
    logic                          valid;
    logic [SAMPLE_BITS-1:0]        data;
  } ssd_top_s;

  ssd_top_s state;
  ssd_top_s next_state;

  ssd_mask_if maskPort ();

  logic                  skipOn;
  logic                  keepBit;
  logic                  lastEdge;
  logic                  wordInStore;
  logic [CNT_BITS-1:0]   limit;
  logic [CNT_BITS-1:0]   edgeNext;
  logic [WORD_BITS-1:0]  bitSelect;

  // ****************************************
  // Mask store
  // ****************************************

  // Mask words stored as 16-bit words [R8]
  // Host writes only between records; no guard
  ssd_mask_store #(.WORDS(WORDS)) u_store (
    .clock       (clock),
    .resetn      (resetn),
    .clockEnable (clockEnable),
    .writeValid  (maskWriteValid),
    .writeIndex  (maskWriteIndex),
    .writeWord   (maskWriteWord),
    .port        (maskPort.store)
  );

  // ****************************************
  // Mode decode
  // ****************************************

  assign skipOn = (skipMode == `SSD_MODE_ON); // [R6]

  // ****************************************
  // Mask lookup
  // ****************************************

  // Word index then bit index, LSB first [R11]
  assign maskPort.readIndex = state.edgeCount[CNT_BITS-2:4];

  // Words past a shallow store read as drop, not unknown
  assign wordInStore = (32'(maskPort.readIndex) < 32'(WORDS));

  // One-hot bit select within the current word [R11]
  for (genvar b = 0; b < WORD_BITS; b++) begin : g_bit
    assign bitSelect[b] = (state.edgeCount[3:0] == 4'(b));
  end

  assign keepBit = wordInStore && (|(bitSelect & maskPort.readWord));

  // ****************************************
  // Record length
  // ****************************************

  // Clamp so the counter never passes the 65536 ceiling [R5]
  assign limit = (recordClockCount > `SSD_MAX_CLOCKS) ? `SSD_MAX_CLOCKS : recordClockCount;

  assign edgeNext = state.edgeCount + 17'h0_0001;

  // Compare against next count so the last edge ends the record
  assign lastEdge = (edgeNext >= limit);

  // ****************************************
  // Next state
  // ****************************************

  always_comb begin
    next_state = state;
    next_state.valid = 1'b0;

    if (!skipOn) begin
      // Plain acquisition, mask and length ignored [R7]
      next_state.fsm = ssd_pkg::SSD_IDLE;
      next_state.edgeCount = '0;
      if (sampleValid) begin
        next_state.valid = 1'b1;
        next_state.data = sampleData;
      end
    end else begin
      unique case (state.fsm)

        ssd_pkg::SSD_IDLE: begin
          // Pre-trigger samples are dropped [R9]
          next_state.edgeCount = '0;
        end

        ssd_pkg::SSD_WALK: begin
          if (sampleValid) begin
            // Keep on one, drop on zero [R1] [R2]
            next_state.valid = keepBit;
            if (keepBit) begin
              next_state.data = sampleData;
            end

            // One bit per edge, record ends at count [R4]
            if (lastEdge) begin
              next_state.fsm = ssd_pkg::SSD_IDLE;
              next_state.edgeCount = '0;
            end else begin
              next_state.edgeCount = edgeNext;
            end
          end
        end

        default: begin
          next_state.fsm = ssd_pkg::SSD_IDLE;
        end

      endcase

      // Trigger restarts from the next edge; wins over record end [R9] [R12]
      // Zero length would still walk one edge, so triggers are ignored then
      if (trigger && limit != '0) begin
        next_state.fsm = ssd_pkg::SSD_WALK;
        next_state.edgeCount = '0;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state.fsm <= ssd_pkg::SSD_IDLE;
      state.edgeCount <= '0;
      state.valid <= 1'b0;
      state.data <= '0;
    end else if (clockEnable) begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Data holds the last kept sample between pulses
  assign outValid = state.valid;
  assign outData = state.data;

  assign recordActive = (state.fsm == ssd_pkg::SSD_WALK);

endmodule : sample_skip_decimator

// ### pkg/ssd_cfg.svh
// Constants for the sample skip decimator
`ifndef SSD_CFG_SVH
`define SSD_CFG_SVH
`define SSD_MODE_OFF      1'h0
`define SSD_MODE_ON       1'h1
`define SSD_MAX_CLOCKS    17'h1_0000
`define SSD_WORD_BITS     16
`define SSD_CNT_BITS      17
`define SSD_MASK_WORDS    4096
`define SSD_WADDR_BITS    12
`define SSD_SAMPLE_BITS   16
`endif

// ### pkg/ssd_pkg.sv
// Types for the sample skip decimator
`include "ssd_cfg.svh"
package ssd_pkg;
  typedef enum logic [1:0] {
    SSD_IDLE = 2'b01,
    SSD_WALK = 2'b10
  } ssd_state_e;
endpackage : ssd_pkg

// ### pkg/ssd_mask_if.sv
// Read port between walker and keep-edge mask store
`timescale 1ns/1ns
`include "ssd_cfg.svh"
interface ssd_mask_if;
  logic [`SSD_WADDR_BITS-1:0] readIndex;
  logic [`SSD_WORD_BITS-1:0]  readWord;
  modport walker (output readIndex, input readWord);
  modport store  (input readIndex, output readWord);
endinterface : ssd_mask_if

// ### hw/ssd_mask_store.sv
// Flip-flop storage of the keep-edge mask words
`timescale 1ns/1ns
`include "ssd_cfg.svh"
module ssd_mask_store #(
  parameter int WORDS = `SSD_MASK_WORDS
) (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic                        clockEnable,
  input  wire logic                        writeValid,
  input  wire logic [`SSD_WADDR_BITS-1:0]  writeIndex,
  input  wire logic [`SSD_WORD_BITS-1:0]   writeWord,
  ssd_mask_if.store                        port
);
  typedef struct packed {
    logic [WORDS-1:0][`SSD_WORD_BITS-1:0] mem;
  } ssd_store_s;
  ssd_store_s state;
  ssd_store_s next_state;
  always_comb begin
    next_state = state;
    if (writeValid) begin
      next_state.mem[writeIndex] = writeWord;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else if (clockEnable) begin
      state <= next_state;
    end
  end
  assign port.readWord = state.mem[port.readIndex];
endmodule : ssd_mask_store

// ### tb/ssd_adc_model.sv
// Converter stream model: new data every clock
`timescale 1ns/1ns
module ssd_adc_model (
  input  wire logic   clock,
  input  wire logic   stall,
  output logic        sampleValid,
  output logic [15:0] sampleData
);
  initial sampleData = '0;
  always @(posedge clock) sampleData <= sampleData + 16'h0001;
  assign sampleValid = !stall;
endmodule : ssd_adc_model

// ### tb/ssd_props.sv
// Checker for the skip decimator ports
`timescale 1ns/1ns
module ssd_props (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        clockEnable,
  input wire logic        skipMode,
  input wire logic        trigger,
  input wire logic        sampleValid,
  input wire logic [15:0] sampleData,
  input wire logic        outValid,
  input wire logic [15:0] outData,
  input wire logic        recordActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_off; clockEnable && !skipMode && sampleValid |=> outValid && outData == $past(sampleData); endproperty
  a_off: assert property (p_off) else $error("lost");
  property p_out; outValid && $past(clockEnable) |-> $past(sampleValid) && outData == $past(sampleData); endproperty
  a_out: assert property (p_out) else $error("spurious");
  property p_pre; clockEnable && skipMode && !recordActive |=> !outValid; endproperty
  a_pre: assert property (p_pre) else $error("early");
  property p_idl; clockEnable && !skipMode |=> !recordActive; endproperty
  a_idl: assert property (p_idl) else $error("walking");
  property p_frz; !clockEnable |=> $stable(outData) && $stable(recordActive); endproperty
  a_frz: assert property (p_frz) else $error("moved");
  property p_go; $rose(recordActive) |-> $past(skipMode && trigger); endproperty
  a_go: assert property (p_go) else $error("start");
  property p_hld; !outValid |-> $stable(outData); endproperty
  a_hld: assert property (p_hld) else $error("data");
  property p_re; clockEnable && skipMode && trigger && recordActive |=> recordActive; endproperty
  a_re: assert property (p_re) else $error("restart");
  c_end: cover property ($fell(recordActive));
  c_re: cover property (recordActive && trigger);
  c_drop: cover property (recordActive ##1 !outValid);
endmodule : ssd_props
bind sample_skip_decimator ssd_props u_ssd_props (.clock, .resetn, .clockEnable, .skipMode, .trigger,
  .sampleValid, .sampleData, .outValid, .outData, .recordActive);

// ### tb/test_sample_skip_decimator.sv
// Bench for the sample skip decimator
`timescale 1ns/1ns
module test_sample_skip_decimator;
  logic        clock = 0, resetn = 0, clockEnable = 1, skipMode = 0, trigger = 0, stall = 0;
  logic        maskWriteValid = 0, sampleValid, outValid, recordActive;
  logic [11:0] maskWriteIndex = '0;
  logic [15:0] maskWriteWord = '0, sampleData, outData, d, last;
  logic [16:0] recordClockCount = 17'h0_0014;
  logic [31:0] mask = 32'h0009_8005;
  int          miscompares = 0, compares = 0, ticks = 0, kept = 0;
  sample_skip_decimator #(.WORDS(64)) u_sample_skip_decimator (.clock, .resetn, .clockEnable, .skipMode,
    .recordClockCount, .maskWriteValid, .maskWriteIndex, .maskWriteWord, .trigger, .sampleValid,
    .sampleData, .outValid, .outData, .recordActive);
  ssd_adc_model u_ssd_adc_model (.clock, .stall, .sampleValid, .sampleData); // One sample per clock while stall is low
  initial forever #2 clock = ~clock;
  task automatic chk(string n, logic [16:0] e, logic [16:0] s);
    compares++;
    if (e !== s) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic results();
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // Off mode: triggers held high must not start a walk
  task automatic passAll();
    trigger = 1;
    for (int i = 0; i < 3; i++) begin
      d = sampleData;
      @(negedge clock);
      chk("out", {1'b1, d}, {outValid, outData});
      chk("active", '0, {16'h0, recordActive});
    end
    {last, trigger, clockEnable, skipMode} = {d, 3'b001};
    @(negedge clock);
    clockEnable = 1;
    @(negedge clock);
    chk("out", {1'b0, last}, {outValid, outData});
  endtask : passAll
  task automatic walk(int stop);
    kept = 0;
    trigger = 1;
    @(negedge clock);
    trigger = 0;
    chk("active", 17'h1, {16'h0, recordActive});
    for (int i = 0; i < stop; i++) begin
      if (i == 3) begin
        stall = 1;
        @(negedge clock);
        stall = 0;
        chk("stall", {1'b0, last}, {outValid, outData});
      end
      d = sampleData;
      @(negedge clock);
      if (i < recordClockCount && mask[i]) last = d;
      chk("out", {i < recordClockCount && mask[i], last}, {outValid, outData});
      if (outValid === 1'b1) kept++;
    end
  endtask : walk
  always @(posedge clock) begin
    ticks++;
    if (ticks == 500) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (20) @(negedge clock);
    resetn = 1;
    for (int w = 0; w < 2; w++) begin
      {maskWriteValid, maskWriteIndex, maskWriteWord} = {1'b1, 12'(w), mask[16*w +: 16]};
      @(negedge clock);
    end
    maskWriteValid = 0;
    passAll();
    walk(7);
    walk(21);
    chk("kept", 17'($countones(mask[19:0])), 17'(kept));
    chk("active", '0, {16'h0, recordActive});
    recordClockCount = '0;
    trigger = 1;
    @(negedge clock);
    trigger = 0;
    chk("zerolen", '0, {16'h0, recordActive});
    results();
  end
endmodule : test_sample_skip_decimator
